// ### two_stage_watchdog.sv
`timescale 1ns/10ps
`include "wdt_defs.svh"

// How it works
// - Timeout drives NMI or INIT, reset follows
// - Bits 0-2 pick one of eight intervals
// - Any register read restarts the count
// - Any register write also restarts the count
// - Power-up clears stage flags and enables
// - Sticky flag marks watchdog-caused reset
// - Count runs from slow RC clock ticks
// - Timeout never earlier than programmed minimum
// - Bit 0x20 enables the hard reset
// - Bit 0x40 reads one after first stage
// - Mask 0x07 interval, code 1 is 500ms
// - Missed strobe with reset enabled resets system
// - First stage leads reset by one stage
// - First stage may request INIT instead
module two_stage_watchdog
  import wdt_pkg::*;
(
  // Clock and power-up reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Slow RC clock pin
  input wire logic slow_clk_i,
  // I/O port access
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Stage outputs
  output logic nmi_o,
  output logic init_o,
  output logic sys_reset_o
);

  // ----------------------------------------
  // Interval decode
  // ----------------------------------------
  function automatic tick_count_t interval_ticks(input logic [2:0] code);
    int t;
    t = 0;
    case (code)
      3'h0: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS0);
      3'h1: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS1);
      3'h2: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS2);
      3'h3: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS3);
      3'h4: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS4);
      3'h5: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS5);
      3'h6: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS6);
      default: t = `WDT_MS_TO_TICKS(`WDT_INTERVAL_MS7);
    endcase
    return t[13:0];
  endfunction

  localparam tick_count_t STAGE_TICKS = tick_count_t'(`WDT_STAGE_TICKS);
  localparam logic [5:0] PULSE_LAST = 6'(`WDT_RESET_PULSE_CYC - 1);

  // ----------------------------------------
  // Slow clock synchroniser
  // ----------------------------------------
  logic slow_meta_reg;
  logic slow_sync_reg;
  logic slow_prev_reg;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      slow_meta_reg <= 1'b0;
      slow_sync_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end
    else
    begin
      slow_meta_reg <= slow_clk_i;
      slow_sync_reg <= slow_meta_reg;
      slow_prev_reg <= slow_sync_reg;
    end
  end

  // One enable per rising RC edge; the strobe acts at once on the fast clock
  wire tick = slow_sync_reg & ~slow_prev_reg;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [2:0] interval_reg;
  logic mode_reg;
  logic en1_reg;
  logic en2_reg;
  logic flag1_reg;
  logic flag2_reg;
  wdt_state_t state_reg;
  wdt_state_t state_next;
  tick_count_t cnt_reg;
  tick_count_t cnt_next;
  logic [5:0] pulse_reg;

  wire addr_hit = (io_addr_i == `WDT_IO_ADDR);
  wire rd_hit = io_rd_i & addr_hit;
  wire wr_hit = io_wr_i & addr_hit;
  wire strobe = rd_hit | wr_hit;
  wire armed = en1_reg | en2_reg;
  wire [7:0] csr_value = {flag2_reg, flag1_reg, en2_reg, en1_reg, mode_reg, interval_reg};
  wire tick_count_t limit = interval_ticks(interval_reg);
  wire tick_count_t cnt_inc = cnt_reg + 14'h0001;
  wire fire1 = (state_reg == ST_COUNT) && (state_next == ST_STAGE1);
  wire fire2 = (state_reg == ST_STAGE1) && (state_next == ST_HOLD);
  wire pulse_done = (pulse_reg == PULSE_LAST);

  // ----------------------------------------
  // Stage sequencer
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_COUNT:
      begin
        if (strobe)
          cnt_next = 14'h0000;
        else if (tick && armed)
        begin
          if (cnt_inc >= limit)
          begin
            state_next = ST_STAGE1;
            cnt_next = 14'h0000;
          end
          else
            cnt_next = cnt_inc;
        end
      end
      ST_STAGE1:
      begin
        // A strobe from the handler cancels the pending reset
        if (strobe || !armed)
        begin
          state_next = ST_COUNT;
          cnt_next = 14'h0000;
        end
        else if (tick)
        begin
          if (cnt_inc >= STAGE_TICKS && en2_reg)
          begin
            state_next = ST_HOLD;
            cnt_next = 14'h0000;
          end
          else if (cnt_inc < STAGE_TICKS)
            cnt_next = cnt_inc;
        end
      end
      ST_HOLD:
      begin
        cnt_next = 14'h0000;
        if (pulse_done)
          state_next = ST_COUNT;
      end
      default:
      begin
        state_next = ST_COUNT;
        cnt_next = 14'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_COUNT;
      cnt_reg <= 14'h0000;
      pulse_reg <= 6'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pulse_reg <= (state_reg == ST_HOLD) ? pulse_reg + 6'h01 : 6'h00;
    end
  end

  // ----------------------------------------
  // Control and status register
  // ----------------------------------------
  // Only rst_i clears flag2, a write-one also clears flag1; the reset this block issues leaves them set
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      interval_reg <= 3'h0;
      mode_reg <= 1'b0;
      en1_reg <= 1'b0;
      en2_reg <= 1'b0;
      flag1_reg <= 1'b0;
      flag2_reg <= 1'b0;
    end
    else
    begin
      if (wr_hit)
      begin
        interval_reg <= io_wdata_i[2:0];
        mode_reg <= io_wdata_i[`WDT_MODE_BIT];
        en1_reg <= io_wdata_i[`WDT_EN1_BIT];
        en2_reg <= io_wdata_i[`WDT_EN2_BIT];
      end
      // Disarm after the hard reset so a slow boot is not reset again
      if (state_reg == ST_HOLD && pulse_done)
      begin
        en1_reg <= 1'b0;
        en2_reg <= 1'b0;
      end
      // Setting wins over a write-one clear in the same cycle
      if (fire1 && en1_reg)
        flag1_reg <= 1'b1;
      else if (wr_hit && io_wdata_i[`WDT_FLAG1_BIT])
        flag1_reg <= 1'b0;
      if (fire2)
        flag2_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      io_rdata_o <= 8'h00;
      nmi_o <= 1'b0;
      init_o <= 1'b0;
      sys_reset_o <= 1'b0;
    end
    else
    begin
      io_rdata_o <= rd_hit ? csr_value : 8'h00;
      nmi_o <= (state_next == ST_STAGE1) && en1_reg && !mode_reg;
      init_o <= (state_next == ST_STAGE1) && en1_reg && mode_reg;
      sys_reset_o <= (state_next == ST_HOLD);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_read_restart;
    rd_hit |=> (cnt_reg == 14'h0000);
  endproperty
  a_read_restart: assert property (p_read_restart) else $error("read did not restart");

  property p_write_fields;
    wr_hit |=> (cnt_reg == 14'h0000) && (interval_reg == $past(io_wdata_i[2:0]));
  endproperty
  a_write_fields: assert property (p_write_fields) else $error("write not applied");

  property p_nmi_out;
    (fire1 && en1_reg && !mode_reg) |=> nmi_o && !init_o && flag1_reg;
  endproperty
  a_nmi_out: assert property (p_nmi_out) else $error("first stage NMI missing");

  property p_init_out;
    (fire1 && en1_reg && mode_reg) |=> init_o && !nmi_o;
  endproperty
  a_init_out: assert property (p_init_out) else $error("first stage INIT missing");

  property p_min_interval;
    fire1 |-> tick && (cnt_inc == limit);
  endproperty
  a_min_interval: assert property (p_min_interval) else $error("timeout early");

  property p_stage_gap;
    fire2 |-> tick && (cnt_inc >= STAGE_TICKS) && en2_reg;
  endproperty
  a_stage_gap: assert property (p_stage_gap) else $error("stage gap wrong");

  property p_no_reset_disabled;
    (!en2_reg && state_reg != ST_HOLD) |=> !sys_reset_o;
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled) else $error("reset not enabled");

  property p_reset_flag;
    fire2 |=> sys_reset_o && flag2_reg ##1 flag2_reg [*8];
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset flag lost");

  property p_tick_single;
    tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

  property p_flag_read;
    (rd_hit && flag1_reg) |=> io_rdata_o[`WDT_FLAG1_BIT];
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("NMI flag not read back");

  c_nmi: cover property (fire1 && en1_reg && !mode_reg);
  c_init: cover property (fire1 && en1_reg && mode_reg);
  c_hard_reset: cover property (fire2);
  c_cancel: cover property (state_reg == ST_STAGE1 && strobe);

endmodule // two_stage_watchdog

// ### wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------
// Register location and field layout
// ----------------------------------------
`define WDT_IO_ADDR 16'h0079
`define WDT_INTERVAL_MASK 8'h07
`define WDT_MODE_BIT 3
`define WDT_EN1_BIT 4
`define WDT_EN2_BIT 5
`define WDT_FLAG1_BIT 6
`define WDT_FLAG2_BIT 7
`define WDT_RESET_ENABLE_MASK 8'h20
`define WDT_NMI_FLAG_MASK 8'h40
`define WDT_RESET_VALUE 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDT_CLK_HZ 50000000
`define WDT_SLOW_MAX_HZ 32
`define WDT_STAGE_MS 250
`define WDT_INTERVAL_MS0 250
`define WDT_INTERVAL_MS1 500
`define WDT_INTERVAL_MS2 1000
`define WDT_INTERVAL_MS3 4000
`define WDT_INTERVAL_MS4 8000
`define WDT_INTERVAL_MS5 32000
`define WDT_INTERVAL_MS6 64000
`define WDT_INTERVAL_MS7 256000
// Slow ticks for a least time; one extra tick covers the phase of the first edge
`define WDT_MS_TO_TICKS(ms) ((((ms) * `WDT_SLOW_MAX_HZ) + 999) / 1000 + 1)
`define WDT_STAGE_TICKS `WDT_MS_TO_TICKS(`WDT_STAGE_MS)
`define WDT_RESET_PULSE_NS 1000
`define WDT_RESET_PULSE_CYC ((`WDT_RESET_PULSE_NS * (`WDT_CLK_HZ / 1000000)) / 1000)

`endif

// ### wdt_pkg.sv
package wdt_pkg;

  typedef enum logic [1:0] {
    ST_COUNT = 2'b00,
    ST_STAGE1 = 2'b01,
    ST_HOLD = 2'b10
  } wdt_state_t;

  typedef logic [13:0] tick_count_t;

endpackage

// ### wdt_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host side of the watchdog I/O port
// ----------------------------------------
module wdt_host_model (
  // Clock and read data
  input wire logic clk_i,
  input wire logic [7:0] io_rdata_i,
  // Port access
  output logic [15:0] io_addr_o,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [7:0] io_wdata_o
);
  initial
  begin
    io_addr_o = 16'hFF86;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_wdata_o = 8'h5A;
  end

  // One access cycle; an idle bus shows inverted values, not the last ones
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_i);
    io_addr_o = a;
    io_wdata_o = d;
    io_rd_o = !wr;
    io_wr_o = wr;
    @(negedge clk_i);
    q = io_rdata_i;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
  endtask
endmodule // wdt_host_model

// ### two_stage_watchdog_tb_top.sv
`timescale 1ns/10ps
module two_stage_watchdog_tb_top;
  localparam int P = 10;
  localparam logic [15:0] A = 16'h0079;
  logic clk_i, rst_i, slow_clk_i, io_rd_i, io_wr_i, nmi_o, init_o, sys_reset_o;
  logic stage_seen;
  logic [15:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o, q;
  int miscompares = 0, n_compared = 0, cyc = 0, n, t;
  int ticks[6] = '{9, 17, 33, 129, 257, 1025};

  two_stage_watchdog u_two_stage_watchdog (.clk_i(clk_i), .rst_i(rst_i),
    .slow_clk_i(slow_clk_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .nmi_o(nmi_o), .init_o(init_o), .sys_reset_o(sys_reset_o));
  wdt_host_model u_wdt_host_model (.clk_i(clk_i), .io_rdata_i(io_rdata_o),
    .io_addr_o(io_addr_i), .io_rd_o(io_rd_i), .io_wr_o(io_wr_i),
    .io_wdata_o(io_wdata_i));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Slow clock of P system cycles, offset so no edge meets a system edge
  initial
  begin
    slow_clk_i = 1'b0;
    #5;
    forever #100 slow_clk_i = ~slow_clk_i;
  end

  always @(negedge clk_i)
  begin
    cyc++;
    if (nmi_o === 1'b1 || init_o === 1'b1)
      stage_seen = 1'b1;
    if (cyc == 30000)
    begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    u_wdt_host_model.acc(1'b0, a, 8'h00, q);
    check("rdata", q, exp);
  endtask

  task automatic wr(input logic [7:0] d);
    u_wdt_host_model.acc(1'b1, A, d, q);
  endtask

  // Strobe lands three cycles after a tick, so the delay is known to a cycle or two
  task automatic align();
    @(posedge slow_clk_i);
    repeat (4) @(negedge clk_i);
  endtask

  task automatic wait_hi(input bit rsel, input int lim, output int k);
    k = 0;
    while (!(rsel ? sys_reset_o === 1'b1 : (nmi_o | init_o) === 1'b1) && k < lim)
    begin
      @(negedge clk_i);
      k++;
    end
  endtask

  task automatic results();
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    rst_i = 1'b1;
    stage_seen = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    check("outs", {5'h00, nmi_o, init_o, sys_reset_o}, 8'h00);
    rd(A, 8'h00);
    rd(16'h0078, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      align();
      wr({4'h1, i[0], i[2:0]});
      wait_hi(1'b0, 12000, n);
      t = n - (ticks[i] - 1) * P;
      check("delay", 8'(t >= 5 && t <= 11), 8'h01);
      check("stage", {6'h00, nmi_o, init_o}, {6'h00, !i[0], i[0]});
      rd(A, {4'h5, i[0], i[2:0]});
      check("cancel", {7'h00, nmi_o | init_o}, 8'h00);
      wr(8'h40);
    end
    align();
    wr(8'h30);
    wait_hi(1'b0, 300, n);
    wait_hi(1'b1, 200, n);
    check("lead", 8'(n >= 88 && n <= 92), 8'h01);
    n = 0;
    while (sys_reset_o === 1'b1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    check("pulse", 8'(n), 8'h32);
    rd(A, 8'hC0);
    wr(8'hFF);
    rd(A, 8'hBF);
    wr(8'h20);
    rd(A, 8'hA0);
    stage_seen = 1'b0;
    for (int j = 0; j < 20; j++)
    begin
      repeat (5 * P) @(negedge clk_i);
      if (j[0])
        wr(8'h20);
      else
        rd(A, 8'hA0);
      check("no reset", {7'h00, sys_reset_o}, 8'h00);
    end
    wait_hi(1'b1, 400, n);
    check("late", 8'(n >= 165 && n <= 195), 8'h01);
    check("quiet", {7'h00, stage_seen}, 8'h00);
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    rd(A, 8'h00);
    results();
  end
endmodule // two_stage_watchdog_tb_top
